//--- csf_defines.vh
// Purpose: Constants for the cyclic synchronous setpoint follower
// Assumes: 32-bit register words at byte offsets
// Notes:   Time base is one millisecond
`ifndef CSF_DEFINES_VH
`define CSF_DEFINES_VH

`define CSF_A_MODE      8'h00
`define CSF_A_CTRL      8'h04
`define CSF_A_STATUS    8'h08
`define CSF_A_TPOS      8'h0c
`define CSF_A_TVEL      8'h10
`define CSF_A_POFS      8'h14
`define CSF_A_VOFS      8'h18
`define CSF_A_SWMIN     8'h1c
`define CSF_A_SWMAX     8'h20
`define CSF_A_RGMIN     8'h24
`define CSF_A_RGMAX     8'h28
`define CSF_A_FEWIN     8'h2c
`define CSF_A_FETMO     8'h30
`define CSF_A_QSDEC     8'h34
`define CSF_A_QSOPT     8'h38
`define CSF_A_MAXSPD    8'h3c
`define CSF_A_IPER      8'h40
`define CSF_A_IIDX      8'h44
`define CSF_A_APOS      8'h48
`define CSF_A_AVEL      8'h4c
`define CSF_A_FEACT     8'h50
`define CSF_A_POL       8'h54

`define CSF_MODE_CSP    8'h08
`define CSF_MODE_CSV    8'h09
`define CSF_IDX_MS      8'hfd

`define CSF_ST_SYNC     8
`define CSF_ST_LIMIT    11
`define CSF_ST_FOLLOW   12
`define CSF_ST_FERR     13

`define CSF_POL_POS     7
`define CSF_POL_VEL     6

`define CSF_RST_IPER    8'h01
`define CSF_RST_MAXSPD  32'h7fffffff

`define CSF_BASE_NS     1000000
`define CSF_CLK_NS      40
`define CSF_CYC_PER_MS  (`CSF_BASE_NS / `CSF_CLK_NS)

`endif

//--- csf_follower.v
// Purpose: Cyclic synchronous position and velocity setpoint follower
// Assumes: Inputs synchronous to mclk, register port never waits
// Notes:   Setpoints pass straight to the demand outputs
//
// How it works
// RQ1: Mode value 8 selects cyclic position
// RQ2: Mode value 9 selects cyclic velocity
// RQ3: Control word bits carry no meaning
// RQ4: Status bit 8 shows fieldbus sync
// RQ5: Position mode bit 12 shows target used
// RQ6: Velocity mode bit 12 shows target used
// RQ7: Bit 13 flags lasting following error
// RQ8: Timeout in ms, symmetric tolerance window
// RQ9: Bit 11 flags demand beyond soft limits
// RQ10: Controller keeps setpoints within soft limits
// RQ11: Range limit wraps position over/underrun
// RQ12: Controller writes position every cycle
// RQ13: Controller writes speed every cycle
// RQ14: Cycle is period times ten power index
// RQ15: Only index -3, 1 ms base
// RQ16: Position offset added to setpoint
// RQ17: Velocity offset added to setpoint
// RQ18: Quick stop brakes with set deceleration
// RQ19: Quick stop follows option code
// RQ20: Speed clamped; position mode closed loop only
// RQ21: No ramps, setpoints followed directly
// RQ22: Actual values and polarity readable
// RQ23: Last setpoint held until next write
`timescale 1ns/10ps
`default_nettype none
`include "csf_defines.vh"

module csf_follower #(
  parameter CYC_PER_MS = `CSF_CYC_PER_MS
) (
  input  wire        mclk,
  input  wire        nrst,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire [31:0] pos_actual,
  input  wire [31:0] vel_actual,
  input  wire        closed_loop,
  input  wire        quick_stop,
  output reg  [31:0] demand_pos,
  output reg  [31:0] demand_vel,
  output reg  [31:0] speed_limit,
  output reg         drive_enable,
  output reg         braking,
  output reg  [15:0] status_word
);

  reg  [7:0]  mode;
  reg  [15:0] ctrl;
  reg  [31:0] tpos;
  reg  [31:0] tvel;
  reg  [31:0] pofs;
  reg  [31:0] vofs;
  reg  [31:0] swmin;
  reg  [31:0] swmax;
  reg  [31:0] rgmin;
  reg  [31:0] rgmax;
  reg  [31:0] fewin;
  reg  [31:0] fetmo;
  reg  [31:0] qsdec;
  reg  [15:0] qsopt;
  reg  [31:0] maxspd;
  reg  [7:0]  iper;
  reg  [7:0]  iidx;
  reg  [7:0]  pol;
  reg  [31:0] ms_div;
  reg  [7:0]  ms_cnt;
  reg         got_set;
  reg         in_sync;
  reg  [31:0] fe_ms;
  reg         fe_flag;
  reg  [31:0] fe_act;
  reg         qs_run;
  reg  [31:0] qs_vel;
  reg  [31:0] next_pos;
  reg  [31:0] next_vel;
  reg  [31:0] next_rdata;
  reg  [31:0] span;
  reg  [31:0] raw_pos;
  reg  [31:0] raw_vel;
  reg  [31:0] lim;
  reg  [31:0] diff;
  reg  [15:0] next_status;
  wire        csp;
  wire        csv;
  wire        ms_tick;
  wire        cyc_end;
  wire        set_wr;
  wire        outside;
  wire        over;

  // RQ1: position mode select
  assign csp = (mode == `CSF_MODE_CSP);
  // RQ2: velocity mode select
  assign csv = (mode == `CSF_MODE_CSV);
  // RQ14: millisecond prescaler
  assign ms_tick = (ms_div == CYC_PER_MS - 1);
  assign cyc_end = ms_tick && (ms_cnt + 8'h01 >= iper);
  // RQ23: fresh setpoint marker
  assign set_wr = wr && ((addr == `CSF_A_TPOS) || (addr == `CSF_A_TVEL));
  // RQ8: symmetric window on absolute error
  assign outside = ($signed(fe_act) > $signed(fewin)) ||
                   ($signed(fe_act) < -$signed(fewin));
  // RQ7: error outlasts timeout
  assign over = (fe_ms > fetmo);

  // Register writes; control word stored only
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      mode   <= 8'h00;
      ctrl   <= 16'h0000;
      tpos   <= 32'h00000000;
      tvel   <= 32'h00000000;
      pofs   <= 32'h00000000;
      vofs   <= 32'h00000000;
      swmin  <= 32'h80000000;
      swmax  <= 32'h7fffffff;
      rgmin  <= 32'h00000000;
      rgmax  <= 32'h00000000;
      fewin  <= 32'h00000000;
      fetmo  <= 32'h00000000;
      qsdec  <= 32'h00000000;
      qsopt  <= 16'h0000;
      maxspd <= `CSF_RST_MAXSPD;
      iper   <= `CSF_RST_IPER;
      iidx   <= `CSF_IDX_MS;
      pol    <= 8'h00;
    end
    else if (wr)
    begin
      if (addr == `CSF_A_MODE)
        mode <= wdata[7:0];
      // RQ3: control bits have no effect
      else if (addr == `CSF_A_CTRL)
        ctrl <= wdata[15:0];
      // RQ23: setpoint held until rewritten
      else if (addr == `CSF_A_TPOS)
        tpos <= wdata;
      else if (addr == `CSF_A_TVEL)
        tvel <= wdata;
      else if (addr == `CSF_A_POFS)
        pofs <= wdata;
      else if (addr == `CSF_A_VOFS)
        vofs <= wdata;
      else if (addr == `CSF_A_SWMIN)
        swmin <= wdata;
      else if (addr == `CSF_A_SWMAX)
        swmax <= wdata;
      else if (addr == `CSF_A_RGMIN)
        rgmin <= wdata;
      else if (addr == `CSF_A_RGMAX)
        rgmax <= wdata;
      else if (addr == `CSF_A_FEWIN)
        fewin <= wdata;
      else if (addr == `CSF_A_FETMO)
        fetmo <= wdata;
      else if (addr == `CSF_A_QSDEC)
        qsdec <= wdata;
      else if (addr == `CSF_A_QSOPT)
        qsopt <= wdata[15:0];
      else if (addr == `CSF_A_MAXSPD)
        maxspd <= wdata;
      else if (addr == `CSF_A_IPER)
        iper <= wdata[7:0];
      // RQ15: only the 1 ms index is accepted
      else if ((addr == `CSF_A_IIDX) && (wdata[7:0] == `CSF_IDX_MS))
        iidx <= wdata[7:0];
      else if (addr == `CSF_A_POL)
        pol <= wdata[7:0];
    end
  end

  // Cycle timer and sync watchdog
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      ms_div  <= 32'h00000000;
      ms_cnt  <= 8'h00;
      got_set <= 1'b0;
      in_sync <= 1'b0;
    end
    else
    begin
      ms_div <= ms_tick ? 32'h00000000 : ms_div + 32'h00000001;
      if (cyc_end)
        ms_cnt <= 8'h00;
      else if (ms_tick)
        ms_cnt <= ms_cnt + 8'h01;
      // RQ4: synced when a setpoint came this cycle
      if (cyc_end)
      begin
        in_sync <= (got_set || set_wr) && (iper != 8'h00) &&
                   (iidx == `CSF_IDX_MS);
        got_set <= set_wr;
      end
      else if (set_wr)
        got_set <= 1'b1;
    end
  end

  // Demand path without ramps
  always @*
  begin
    span = rgmax - rgmin + 32'h00000001;
    // RQ16: position offset
    raw_pos = tpos + pofs;
    // RQ17: velocity offset
    raw_vel = tvel + vofs;
    next_pos = raw_pos;
    // RQ11: range limit wraps the demand
    if ($signed(rgmax) > $signed(rgmin))
    begin
      if ($signed(raw_pos) > $signed(rgmax))
        next_pos = raw_pos - span;
      else if ($signed(raw_pos) < $signed(rgmin))
        next_pos = raw_pos + span;
    end
    // RQ20: speed limit, closed loop only in position mode
    lim = (csv || closed_loop) ? maxspd : `CSF_RST_MAXSPD;
    next_vel = raw_vel;
    if ($signed(raw_vel) > $signed(lim))
      next_vel = lim;
    else if ($signed(raw_vel) < -$signed(lim))
      next_vel = -lim;
    diff = demand_pos - pos_actual;
  end

  // Outputs, quick stop and following error
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      demand_pos   <= 32'h00000000;
      demand_vel   <= 32'h00000000;
      speed_limit  <= `CSF_RST_MAXSPD;
      drive_enable <= 1'b0;
      braking      <= 1'b0;
      qs_run       <= 1'b0;
      qs_vel       <= 32'h00000000;
      fe_act       <= 32'h00000000;
      fe_ms        <= 32'h00000000;
      fe_flag      <= 1'b0;
    end
    else
    begin
      speed_limit <= lim;
      fe_act      <= diff;
      if (quick_stop && !qs_run && (csp || csv))
      begin
        qs_run <= 1'b1;
        qs_vel <= csv ? next_vel : vel_actual;
      end
      else if (!quick_stop && qs_run)
        qs_run <= 1'b0;
      if (qs_run)
      begin
        // RQ19: option zero drops the drive at once
        drive_enable <= (qsopt != 16'h0000);
        braking      <= (qsopt != 16'h0000);
        demand_pos   <= pos_actual;
        demand_vel   <= qs_vel;
        // RQ18: brake by set deceleration per ms
        if (ms_tick)
        begin
          if ($signed(qs_vel) > $signed(qsdec))
            qs_vel <= qs_vel - qsdec;
          else if ($signed(qs_vel) < -$signed(qsdec))
            qs_vel <= qs_vel + qsdec;
          else
            qs_vel <= 32'h00000000;
        end
      end
      else
      begin
        braking      <= 1'b0;
        drive_enable <= csp || csv;
        // RQ21: setpoint taken straight over
        if (csp)
          demand_pos <= next_pos;
        if (csv)
          demand_vel <= next_vel;
        else
          demand_vel <= 32'h00000000;
      end
      // RQ7: timed following error in position mode
      if (!csp || !outside)
      begin
        fe_ms   <= 32'h00000000;
        fe_flag <= 1'b0;
      end
      else
      begin
        // RQ8: timeout counted in milliseconds
        if (ms_tick && !over)
          fe_ms <= fe_ms + 32'h00000001;
        if (over)
          fe_flag <= 1'b1;
      end
    end
  end

  // Status word
  always @*
  begin
    next_status = 16'h0000;
    if (csp || csv)
    begin
      // RQ4: sync bit
      next_status[`CSF_ST_SYNC] = in_sync;
      // RQ5: position target used
      // RQ6: velocity target used
      next_status[`CSF_ST_FOLLOW] = drive_enable && !qs_run;
    end
    if (csp)
    begin
      // RQ9: demand beyond soft limits
      next_status[`CSF_ST_LIMIT] = ($signed(demand_pos) > $signed(swmax)) ||
                                   ($signed(demand_pos) < $signed(swmin));
      next_status[`CSF_ST_FERR] = fe_flag;
    end
  end

  // Read mux; unmapped reads give zero
  always @*
  begin
    next_rdata = 32'h00000000;
    if (addr == `CSF_A_MODE)
      next_rdata = {24'h000000, mode};
    else if (addr == `CSF_A_CTRL)
      next_rdata = {16'h0000, ctrl};
    else if (addr == `CSF_A_STATUS)
      next_rdata = {16'h0000, status_word};
    else if (addr == `CSF_A_TPOS)
      next_rdata = tpos;
    else if (addr == `CSF_A_TVEL)
      next_rdata = tvel;
    else if (addr == `CSF_A_POFS)
      next_rdata = pofs;
    else if (addr == `CSF_A_VOFS)
      next_rdata = vofs;
    else if (addr == `CSF_A_SWMIN)
      next_rdata = swmin;
    else if (addr == `CSF_A_SWMAX)
      next_rdata = swmax;
    else if (addr == `CSF_A_RGMIN)
      next_rdata = rgmin;
    else if (addr == `CSF_A_RGMAX)
      next_rdata = rgmax;
    else if (addr == `CSF_A_FEWIN)
      next_rdata = fewin;
    else if (addr == `CSF_A_FETMO)
      next_rdata = fetmo;
    else if (addr == `CSF_A_QSDEC)
      next_rdata = qsdec;
    else if (addr == `CSF_A_QSOPT)
      next_rdata = {16'h0000, qsopt};
    else if (addr == `CSF_A_MAXSPD)
      next_rdata = maxspd;
    else if (addr == `CSF_A_IPER)
      next_rdata = {24'h000000, iper};
    else if (addr == `CSF_A_IIDX)
      next_rdata = {24'h000000, iidx};
    // RQ22: actual values readable
    else if (addr == `CSF_A_APOS)
      next_rdata = pos_actual;
    else if (addr == `CSF_A_AVEL)
      next_rdata = vel_actual;
    else if (addr == `CSF_A_FEACT)
      next_rdata = fe_act;
    else if (addr == `CSF_A_POL)
      next_rdata = {24'h000000, pol};
  end
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      rdata       <= 32'h00000000;
      status_word <= 16'h0000;
    end
    else
    begin
      status_word <= next_status;
      rdata       <= rd ? next_rdata : 32'h00000000;
    end
  end
endmodule

`default_nettype wire

//--- csf_follower_props.sv
// Purpose: Port assertions for csf_follower
// Assumes: One clock, sync active-low reset
// Notes:   Shadows track written settings
`timescale 1ns/10ps
`default_nettype none
module csf_follower_props (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        closed_loop,
  input wire logic        quick_stop,
  input wire logic [31:0] demand_pos,
  input wire logic [31:0] demand_vel,
  input wire logic [31:0] speed_limit,
  input wire logic        drive_enable,
  input wire logic        braking,
  input wire logic [15:0] status_word
);
  logic [7:0]  mode_s;
  logic [31:0] pofs_s;
  logic [31:0] vofs_s;
  logic [31:0] rgmax_s;
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      mode_s <= 8'h00;
      pofs_s <= 32'h0;
      vofs_s <= 32'h0;
      rgmax_s <= 32'h0;
    end
    else if (wr)
    begin
      if (addr == 8'h00)
        mode_s <= wdata[7:0];
      if (addr == 8'h14)
        pofs_s <= wdata;
      if (addr == 8'h18)
        vofs_s <= wdata;
      if (addr == 8'h28)
        rgmax_s <= wdata;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  chk_reset_vals: assert property (disable iff (1'b0)
    !nrst |=> demand_pos == 0 && status_word == 0
    && speed_limit == 32'h7fffffff) else $error("bad reset value");
  chk_rdata_idle: assert property (
    !$past(rd) |-> rdata == 0) else $error("rdata not zero");
  chk_pos_offset: assert property (
    wr && addr == 8'h0c && mode_s == 8'h08 && !quick_stop && rgmax_s == 0
    |-> ##2 demand_pos == $past(wdata, 2) + pofs_s)
    else $error("demand pos wrong");
  chk_vel_offset: assert property (
    wr && addr == 8'h10 && mode_s == 8'h09 && !quick_stop
    |-> ##2 demand_vel == $past(wdata, 2) + vofs_s)
    else $error("demand vel wrong");
  chk_pos_hold: assert property (
    mode_s == 8'h08 && !$past(wr) && !$past(wr, 2) && !quick_stop
    && !$past(quick_stop) && !braking |-> $stable(demand_pos))
    else $error("demand pos moved");
  chk_mode_enable: assert property (
    !$past(wr) && !quick_stop && !$past(quick_stop) && !braking
    |-> drive_enable == (mode_s == 8'h08 || mode_s == 8'h09))
    else $error("enable not per mode");
  chk_brake_enable: assert property (
    braking |-> drive_enable) else $error("brake without enable");
  chk_brake_cause: assert property (
    $rose(braking) |-> $past(quick_stop)) else $error("brake uncaused");
  chk_open_loop: assert property (
    mode_s == 8'h08 && !$past(wr) && !$past(closed_loop)
    |-> speed_limit == 32'h7fffffff) else $error("open loop capped");
endmodule
`default_nettype wire

//--- csf_plant.sv
// Purpose: Motor and encoder stand-in
// Assumes: Follows demand one clock late
// Notes:   Lag input sets the position error
`timescale 1ns/10ps
`default_nettype none
module csf_plant (
  input  wire logic        mclk,
  input  wire logic [31:0] demand_pos,
  input  wire logic [31:0] lag,
  input  wire logic [31:0] vel_set,
  output var  logic [31:0] pos_actual,
  output var  logic [31:0] vel_actual
);
  always @(posedge mclk)
  begin
    pos_actual <= demand_pos - lag;
    vel_actual <= vel_set;
  end
endmodule
`default_nettype wire

//--- csf_follower_tb.sv
// Purpose: Self-checking bench for csf_follower
// Assumes: Short millisecond count
// Notes:   One task per scenario
`timescale 1ns/10ps
`default_nettype none
module csf_follower_tb;
  localparam int CPM = 8;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        closed_loop = 1'b0;
  logic        quick_stop = 1'b0;
  logic [31:0] lag = 32'h0;
  logic [31:0] vel_set = 32'h0;
  wire  [31:0] rdata, pos_actual, vel_actual, demand_pos, demand_vel;
  wire  [31:0] speed_limit;
  wire  [15:0] status_word;
  wire         drive_enable, braking;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  always #20 mclk = ~mclk;
  csf_follower #(.CYC_PER_MS(CPM)) dut (.mclk, .nrst, .addr, .wdata, .wr,
    .rd, .rdata, .pos_actual, .vel_actual, .closed_loop, .quick_stop,
    .demand_pos, .demand_vel, .speed_limit, .drive_enable, .braking,
    .status_word);
  csf_plant u_plant (.mclk, .demand_pos, .lag, .vel_set, .pos_actual,
    .vel_actual);
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e,
    input string n);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask
  task automatic feed(input logic [7:0] a, input logic [31:0] d);
    repeat (4)
    begin
      wreg(a, d);
      wait_c(CPM - 2);
    end
  endtask
  task automatic t_reset;
    logic [7:0]  ad [0:7];
    logic [31:0] ex [0:7];
    ad = '{8'h00, 8'h08, 8'h40, 8'h44, 8'h1c, 8'h20, 8'h3c, 8'hfc};
    ex = '{0, 0, 1, 32'hfd, 32'h80000000, 32'h7fffffff, 32'h7fffffff, 0};
    for (int i = 0; i < 8; i++)
      rreg(ad[i], ex[i], "reset reg");
    wreg(8'h44, 32'h0);
    wreg(8'h08, 32'hffff);
    rreg(8'h44, 32'hfd, "index");
    rreg(8'h08, 32'h0, "status");
    $display("reset done");
  endtask
  task automatic t_pos;
    wreg(8'h14, 32'd5);
    wreg(8'h00, 32'h8);
    wreg(8'h04, 32'h0);
    wreg(8'h0c, 32'd100);
    wait_c(3);
    chk("dpos", 32'd105, demand_pos);
    wreg(8'h04, 32'h10);
    wait_c(20);
    chk("dpos held", 32'd105, demand_pos);
    feed(8'h0c, 32'd100);
    chk("sync", 1, status_word[8]);
    chk("follow", 1, status_word[12]);
    wait_c(3 * CPM);
    chk("sync lost", 0, status_word[8]);
    wreg(8'h40, 32'h2);
    repeat (3)
    begin
      wreg(8'h0c, 32'd100);
      wait_c(2 * CPM - 2);
    end
    chk("sync 2ms", 1, status_word[8]);
    wreg(8'h40, 32'h0);
    feed(8'h0c, 32'd100);
    chk("no period", 0, status_word[8]);
    wreg(8'h40, 32'h1);
    $display("position done");
  endtask
  task automatic t_limit;
    wreg(8'h20, 32'd1000);
    // Setpoint beyond the upper bound on purpose
    wreg(8'h0c, 32'd2000);
    wait_c(4);
    chk("above", 1, status_word[11]);
    wreg(8'h0c, 32'd500);
    wait_c(4);
    chk("inside", 0, status_word[11]);
    wreg(8'h1c, 32'd600);
    wait_c(4);
    chk("below", 1, status_word[11]);
    wreg(8'h1c, 32'h80000000);
    wreg(8'h20, 32'h7fffffff);
    $display("limit done");
  endtask
  task automatic t_ferr;
    wreg(8'h2c, 32'd10);
    wreg(8'h30, 32'd2);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk);
      lag <= i ? 32'hfffffff5 : 32'h0000000b;
      wait_c(12);
      chk("ferr early", 0, status_word[13]);
      wait_c(28);
      chk("ferr", 1, status_word[13]);
      rreg(8'h50, lag, "fe actual");
      @(posedge mclk);
      lag <= 32'h0;
      wait_c(4);
      chk("ferr clear", 0, status_word[13]);
    end
    @(posedge mclk);
    lag <= 32'd10;
    wait_c(40);
    chk("ferr edge", 0, status_word[13]);
    rreg(8'h48, 32'd495, "apos");
    $display("ferr done");
  endtask
  task automatic t_wrap;
    wreg(8'h28, 32'd1000);
    wreg(8'h0c, 32'd1200);
    wait_c(3);
    chk("wrap over", 32'd204, demand_pos);
    wreg(8'h0c, 32'hfffffff6);
    wait_c(3);
    chk("wrap under", 32'd996, demand_pos);
    wreg(8'h28, 32'h0);
    $display("wrap done");
  endtask
  task automatic t_vel;
    vel_set <= 32'd77;
    wreg(8'h18, 32'd3);
    wreg(8'h3c, 32'd500);
    wreg(8'h00, 32'h9);
    feed(8'h10, 32'd100);
    chk("dvel", 32'd103, demand_vel);
    chk("vfollow", 1, status_word[12]);
    chk("vsync", 1, status_word[8]);
    chk("vcap", 32'd500, speed_limit);
    rreg(8'h4c, 32'd77, "avel");
    wreg(8'h54, 32'hc0);
    rreg(8'h54, 32'hc0, "polarity");
    wreg(8'h00, 32'h8);
    closed_loop <= 1'b1;
    wait_c(3);
    chk("pcap", 32'd500, speed_limit);
    $display("velocity done");
  endtask
  task automatic t_qs;
    closed_loop <= 1'b0;
    wreg(8'h00, 32'h9);
    wreg(8'h38, 32'h1);
    wreg(8'h34, 32'd20);
    wreg(8'h10, 32'd100);
    wait_c(3);
    quick_stop <= 1'b1;
    wait_c(20);
    chk("braking", 1, braking);
    chk("qs follow", 0, status_word[12]);
    chk("slowing", 1, demand_vel < 103 && demand_vel > 0);
    wait_c(80);
    chk("stopped", 0, demand_vel);
    quick_stop <= 1'b0;
    wreg(8'h38, 32'h0);
    wait_c(3);
    quick_stop <= 1'b1;
    wait_c(3);
    chk("drive off", 0, drive_enable);
    chk("no brake", 0, braking);
    $display("quick stop done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_pos;
    t_limit;
    t_ferr;
    t_wrap;
    t_vel;
    t_qs;
    give_verdict;
  end
endmodule
bind csf_follower csf_follower_props u_props (.mclk, .nrst, .addr, .wdata,
  .wr, .rd, .rdata, .closed_loop, .quick_stop, .demand_pos, .demand_vel,
  .speed_limit, .drive_enable, .braking, .status_word);
`default_nettype wire
